/* File: verilog/deac_ctrl.sv */
// Nonvolatile memory access control: registers, unlock and write timer.
`timescale 1ns/10ps
`include "deac_map.svh"

module deac_ctrl
  import deac_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int WRITE_CYCLES = `DEAC_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic warm_reset_n,
  input wire deac_req_s bus_req,
  output logic [7:0] bus_rdata,
  output logic write_done_irq_flag
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam logic [15:0] LAST_CNT = 16'(WRITE_CYCLES - 1);

  logic [7:0] mem [0:DEPTH-1];
  logic [2:0] warm_sync_r;
  logic warm_lvl_r, warm_lvl_nxt;
  logic sel_r, sel_nxt;
  logic abort_r, abort_nxt;
  logic permit_r, permit_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] rdata_nxt;
  deac_unlock_e unl_r, unl_nxt;
  logic ctrl_wr, unl_wr, data_wr, rd_req, start, done, mem_we;
  logic [7:0] mem_rd_val;

  function automatic logic hit(input deac_req_s r, input logic [8:0] ofs);
    hit = (r.addr == ofs);
  endfunction

  assign mem_rd_val = mem[addr_r];

  // ----------------------------------------------------------------------
  // Warm reset pin filter
  // ----------------------------------------------------------------------
  // The pin is asynchronous; a new level counts once two stages agree.
  always_comb begin
    warm_lvl_nxt = warm_lvl_r;
    if (warm_sync_r[1] == warm_sync_r[2]) begin
      warm_lvl_nxt = warm_sync_r[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      warm_sync_r <= 3'h7;
      warm_lvl_r <= 1'b1;
    end else begin
      warm_sync_r <= {warm_sync_r[1:0], warm_reset_n};
      warm_lvl_r <= warm_lvl_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Register file, unlock and write timer
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_wr = bus_req.we && hit(bus_req, `DEAC_OFS_CTRL);
    unl_wr = bus_req.we && hit(bus_req, `DEAC_OFS_UNLOCK);
    data_wr = bus_req.we && hit(bus_req, `DEAC_OFS_DATA);
    // The permit bit is taken before this write, so setting both at once
    // cannot start a write.
    start = ctrl_wr && bus_req.wdata[`DEAC_BIT_WR] && permit_r && !wr_r &&
            (unl_r == DEAC_UNL_ARMED) && warm_lvl_r;
    done = wr_r && (cnt_r == LAST_CNT);
    rd_req = ctrl_wr && bus_req.wdata[`DEAC_BIT_RD] && !rd_r;
    sel_nxt = sel_r;
    abort_nxt = abort_r;
    permit_nxt = permit_r;
    wr_nxt = wr_r;
    rd_nxt = 1'b0;
    irq_nxt = irq_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    cnt_nxt = cnt_r;
    unl_nxt = unl_r;
    mem_we = 1'b0;
    // Any other write breaks the unlock sequence.
    if (bus_req.we) begin
      unl_nxt = DEAC_UNL_IDLE;
      if (unl_wr && bus_req.wdata == `DEAC_KEY_FIRST) begin
        unl_nxt = DEAC_UNL_GOT_FIRST;
      end
      if (unl_wr && bus_req.wdata == `DEAC_KEY_SECOND &&
          unl_r == DEAC_UNL_GOT_FIRST) begin
        unl_nxt = DEAC_UNL_ARMED;
      end
    end
    if (ctrl_wr) begin
      sel_nxt = bus_req.wdata[`DEAC_BIT_SEL];
      abort_nxt = bus_req.wdata[`DEAC_BIT_ABORT];
      permit_nxt = bus_req.wdata[`DEAC_BIT_PERMIT];
    end
    if (bus_req.we && hit(bus_req, `DEAC_OFS_ADDR)) begin
      addr_nxt = bus_req.wdata;
    end
    if (data_wr) begin
      data_nxt = bus_req.wdata;
    end
    if (bus_req.we && hit(bus_req, `DEAC_OFS_IRQ) &&
        !bus_req.wdata[`DEAC_BIT_IRQ]) begin
      irq_nxt = 1'b0;
    end
    if (rd_req) begin
      rd_nxt = 1'b1;
      // Program memory reads are served outside; data stays untouched.
      if (!sel_nxt) begin
        data_nxt = mem_rd_val;
      end
    end
    if (start) begin
      wr_nxt = 1'b1;
      cnt_nxt = 16'h0000;
    end else if (wr_r) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (done) begin
      wr_nxt = 1'b0;
      irq_nxt = 1'b1;
      abort_nxt = 1'b0;
      mem_we = !sel_r;
    end
    if (!warm_lvl_r) begin
      // Address, data and select survive a warm reset so software can
      // retry the interrupted location.
      abort_nxt = abort_r | wr_r;
      permit_nxt = 1'b0;
      wr_nxt = 1'b0;
      rd_nxt = 1'b0;
      mem_we = 1'b0;
      unl_nxt = DEAC_UNL_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_r <= `DEAC_RST_BIT;
      abort_r <= `DEAC_RST_BIT;
      permit_r <= `DEAC_RST_BIT;
      wr_r <= `DEAC_RST_BIT;
      rd_r <= `DEAC_RST_BIT;
      irq_r <= `DEAC_RST_BIT;
      addr_r <= `DEAC_BYTE_ZERO;
      data_r <= `DEAC_BYTE_ZERO;
      cnt_r <= 16'h0000;
      unl_r <= DEAC_UNL_IDLE;
    end else begin
      sel_r <= sel_nxt;
      abort_r <= abort_nxt;
      permit_r <= permit_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      irq_r <= irq_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      cnt_r <= cnt_nxt;
      unl_r <= unl_nxt;
    end
  end

  // The array has no reset; its contents are nonvolatile by intent.
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[addr_r] <= data_r;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = `DEAC_BYTE_ZERO;
    if (bus_req.re) begin
      unique case (bus_req.addr)
        `DEAC_OFS_CTRL:
          rdata_nxt = {sel_r, 3'h0, abort_r, permit_r, wr_r, rd_r};
        `DEAC_OFS_DATA: rdata_nxt = data_r;
        `DEAC_OFS_ADDR: rdata_nxt = addr_r;
        `DEAC_OFS_IRQ: rdata_nxt = {7'h00, irq_r};
        default: rdata_nxt = `DEAC_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_rdata <= `DEAC_BYTE_ZERO;
      write_done_irq_flag <= `DEAC_RST_BIT;
    end else begin
      bus_rdata <= rdata_nxt;
      write_done_irq_flag <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  unimpl_bits_a: assert property (
    bus_req.re && bus_req.addr == `DEAC_OFS_CTRL |=> bus_rdata[6:4] == 3'h0)
    else $error("Unimplemented control bits read nonzero.");

  abort_set_a: assert property (
    wr_r && !warm_lvl_r |=> abort_r && !wr_r)
    else $error("Cut write did not raise abort flag.");

  wr_hold_a: assert property (
    wr_r && !done && warm_lvl_r |=> wr_r)
    else $error("Write strobe dropped before completion.");

  rd_pulse_a: assert property (
    rd_r |=> !rd_r)
    else $error("Read strobe not cleared by hardware.");

  read_fetch_a: assert property (
    rd_req && !sel_nxt && warm_lvl_r |=> data_r == $past(mem_rd_val))
    else $error("Read data not ready in next cycle.");

  data_keep_a: assert property (
    !rd_req && !data_wr |=> $stable(data_r))
    else $error("Data register changed without cause.");

  unlock_gate_a: assert property (
    $rose(wr_r) |-> $past(unl_r) == DEAC_UNL_ARMED)
    else $error("Write started without unlock sequence.");

  permit_gate_a: assert property (
    $rose(wr_r) |-> $past(permit_r))
    else $error("Write started without prior permit.");

  done_flag_a: assert property (
    done && warm_lvl_r |=> !wr_r && write_done_irq_flag)
    else $error("Completion did not clear strobe and set flag.");

  unlock_zero_a: assert property (
    bus_req.re && bus_req.addr == `DEAC_OFS_UNLOCK |=> bus_rdata == 8'h00)
    else $error("Unlock port read nonzero.");

  write_done_c: cover property (done ##1 write_done_irq_flag);
  read_c: cover property (rd_req && !sel_nxt);
  abort_c: cover property (wr_r && !warm_lvl_r);
  arm_c: cover property (unl_r == DEAC_UNL_ARMED && ctrl_wr && !start);

endmodule

/* File: verilog/deac_map.svh */
// Register offsets, field positions, key values and reset values.
`ifndef DEAC_MAP_SVH
`define DEAC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DEAC_ADDR_W 9
`define DEAC_OFS_DATA 9'h10C
`define DEAC_OFS_ADDR 9'h10D
`define DEAC_OFS_IRQ 9'h10E
`define DEAC_OFS_CTRL 9'h18C
`define DEAC_OFS_UNLOCK 9'h18D

// ----------------------------------------------------------------------
// Control and interrupt register fields
// ----------------------------------------------------------------------
`define DEAC_BIT_SEL 7
`define DEAC_BIT_ABORT 3
`define DEAC_BIT_PERMIT 2
`define DEAC_BIT_WR 1
`define DEAC_BIT_RD 0
`define DEAC_BIT_IRQ 0

// ----------------------------------------------------------------------
// Unlock keys and reset values
// ----------------------------------------------------------------------
`define DEAC_KEY_FIRST 8'h55
`define DEAC_KEY_SECOND 8'hAA
`define DEAC_BYTE_ZERO 8'h00
`define DEAC_RST_BIT 1'b0
`define DEAC_WRITE_CYCLES 64

`endif

/* File: verilog/deac_pkg.sv */
// Types shared by the nonvolatile access control block.
package deac_pkg;

  // ----------------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } deac_req_s;

  // ----------------------------------------------------------------------
  // Unlock sequence tracker, Gray coded
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DEAC_UNL_IDLE = 2'h0,
    DEAC_UNL_GOT_FIRST = 2'h1,
    DEAC_UNL_ARMED = 2'h3
  } deac_unlock_e;

endpackage

/* File: sim/deac_ctrl_bench.sv */
// Self-checking bench for the nonvolatile access control block.
`timescale 1ns/10ps
`include "deac_map.svh"
module deac_ctrl_bench
  import deac_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  logic warm_reset_n;
  deac_req_s bus_req;
  logic [7:0] bus_rdata;
  logic write_done_irq_flag;
  int miscompares;
  int checked;

  // A 16-cycle write timer, shorter than the default 64, still leaves room for the warm reset filter to act.
  deac_ctrl #(.DEPTH(256), .WRITE_CYCLES(16)) i_deac_ctrl (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .warm_reset_n(warm_reset_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .write_done_irq_flag(write_done_irq_flag)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus_req <= deac_req_s'{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    bus_req <= deac_req_s'{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (e !== g) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_flag();
    int n;
    for (n = 0; n < 40 && write_done_irq_flag !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (write_done_irq_flag !== 1'b1) begin
      miscompares++;
      $display("wrong value flag wait expected 1 seen timeout");
      wrap_up();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl reset", 8'h00, v);
    chk("flag reset", 8'h00, {7'h00, write_done_irq_flag});
    wr(`DEAC_OFS_UNLOCK, 8'h5A);
    rd(`DEAC_OFS_UNLOCK, v);
    chk("unlock read", 8'h00, v);
    rd(9'h100, v);
    chk("unmapped read", 8'h00, v);
    wr(`DEAC_OFS_CTRL, 8'hF0);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl reserved", 8'h80, v);
    wr(`DEAC_OFS_CTRL, 8'h00);
  endtask

  task automatic t_write();
    logic [7:0] v;
    wr(`DEAC_OFS_ADDR, 8'h3C);
    wr(`DEAC_OFS_DATA, 8'hA5);
    wr(`DEAC_OFS_CTRL, 8'h04);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_FIRST);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_SECOND);
    wr(`DEAC_OFS_CTRL, 8'h06);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl started", 8'h06, v);
    wr(`DEAC_OFS_CTRL, 8'h04);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl zero write", 8'h06, v);
    wait_flag();
    @(posedge ref_clk);
    #1;
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl finished", 8'h04, v);
    chk("flag sticky", 8'h01, {7'h00, write_done_irq_flag});
    wr(`DEAC_OFS_IRQ, 8'h00);
    chk("flag cleared", 8'h00, {7'h00, write_done_irq_flag});
  endtask

  task automatic t_read();
    logic [7:0] v;
    wr(`DEAC_OFS_DATA, 8'h00);
    rd(`DEAC_OFS_DATA, v);
    chk("data sw write", 8'h00, v);
    wr(`DEAC_OFS_ADDR, 8'h3C);
    wr(`DEAC_OFS_CTRL, 8'h01);
    rd(`DEAC_OFS_DATA, v);
    chk("data next cycle", 8'hA5, v);
    rd(`DEAC_OFS_DATA, v);
    chk("data held", 8'hA5, v);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl read done", 8'h00, v);
    // A read with program memory selected must leave the data register alone.
    wr(`DEAC_OFS_CTRL, 8'h81);
    rd(`DEAC_OFS_DATA, v);
    chk("data prog read", 8'hA5, v);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl prog read", 8'h80, v);
  endtask

  task automatic t_locked();
    logic [7:0] v;
    wr(`DEAC_OFS_CTRL, 8'h06);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl same write", 8'h04, v);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_FIRST);
    wr(`DEAC_OFS_ADDR, 8'h3C);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_SECOND);
    wr(`DEAC_OFS_CTRL, 8'h06);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl broken keys", 8'h04, v);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_SECOND);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_FIRST);
    wr(`DEAC_OFS_CTRL, 8'h06);
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl keys swapped", 8'h04, v);
  endtask

  task automatic t_warm();
    logic [7:0] v;
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_FIRST);
    wr(`DEAC_OFS_UNLOCK, `DEAC_KEY_SECOND);
    wr(`DEAC_OFS_CTRL, 8'h06);
    warm_reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    warm_reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    rd(`DEAC_OFS_CTRL, v);
    chk("ctrl aborted", 8'h08, v);
    rd(`DEAC_OFS_ADDR, v);
    chk("addr kept", 8'h3C, v);
  endtask

  initial begin
    miscompares = 0;
    checked = 0;
    rst_n = 1'b0;
    warm_reset_n = 1'b1;
    bus_req = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_write();
    t_read();
    t_locked();
    t_warm();
    wrap_up();
  end
endmodule
